/* File: shared/gdb_pkg.sv */
// package for the banked gpio data path: register map and state layout
package gdb_pkg;
  localparam int GDB_PORTS = 64;
  localparam int GDB_BANKS = 8;
  localparam int GDB_ADDR_W = 12;
  // register indexes; byte address is four times the index
  localparam logic [7:0] GDB_IDX_BANK_ONE = 8'h4b;
  localparam logic [7:0] GDB_IDX_BANK_TWO = 8'h4c;
  localparam logic [7:0] GDB_IDX_BANK_THREE = 8'h4d;
  localparam logic [7:0] GDB_IDX_BANK_FOUR = 8'h4e;
  localparam logic [7:0] GDB_IDX_BANK_FIVE = 8'h4f;
  localparam logic [7:0] GDB_IDX_BANK_SIX = 8'h50;
  localparam logic [7:0] GDB_IDX_BANK_SEVEN = 8'h51;
  localparam logic [7:0] GDB_IDX_BANK_EIGHT = 8'h4a;
  localparam logic [7:0][7:0] GDB_BANK_IDX = {GDB_IDX_BANK_EIGHT,
    GDB_IDX_BANK_SEVEN, GDB_IDX_BANK_SIX, GDB_IDX_BANK_FIVE,
    GDB_IDX_BANK_FOUR, GDB_IDX_BANK_THREE, GDB_IDX_BANK_TWO,
    GDB_IDX_BANK_ONE};
  // reserved bit positions per bank, read zero and ignore writes
  localparam logic [7:0][7:0] GDB_BANK_RSVD = {8'h00, 8'h00, 8'hf8, 8'h00,
    8'hf0, 8'h00, 8'h00, 8'h00};
  // per-port configuration registers start here, one index per port
  localparam logic [7:0] GDB_IDX_CFG_BASE = 8'h80;
  // address bit that selects the configuration-space alias window
  localparam int GDB_WIN_BIT = 11;
  // configuration field positions
  localparam int GDB_CFG_DIR = 0;
  localparam int GDB_CFG_INV = 1;
  localparam int GDB_CFG_ODRAIN = 7;
  localparam logic [7:0] GDB_CFG_RST = 8'h01;
  localparam logic [63:0] GDB_DATA_RST = 64'h0;
  localparam logic [1:0] GDB_RESP_OKAY = 2'h0;
  localparam logic [1:0] GDB_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [63:0][7:0] cfg;
    logic [63:0] data;
    logic aw_have;
    logic [GDB_ADDR_W-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [63:0] pin_out;
    logic [63:0] pin_oe;
    logic [63:0] wake;
  } gdb_state_type;
endpackage

/* File: verilog/gdb_top.sv */
// banked gpio data path with per-port configuration, axi4-lite slave
// Behaviour
// - every port owns one data bit and its own eight-bit config register.
// - port data bits sit at fixed positions in eight byte-wide banks.
// - reading an input port's bank bit returns the sampled pin level xor its config inversion bit.
// - a written bank bit of an output port is held and driven on the pin xor its inversion bit; open drain only pulls low.
// - bank contents latch at each access: reads snapshot, writes update.
// - all registers answer both in the runtime and the config window.
// - wakeup-capable ports feed a standby-powered wake input path.
// - config bit 0 picks direction, bit 1 inversion, bit 7 open drain.
`timescale 1ns/1ps
module gdb_top import gdb_pkg::*; #(
  parameter logic [63:0] WAKE_MASK = 64'hffffffffffffffff
) (
  input wire logic clk, // 125 mhz
  input wire logic rstn, // async, active low
  input wire logic [GDB_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [GDB_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [63:0] pin_in, // pin levels
  output logic [63:0] pin_out, // pin drive level
  output logic [63:0] pin_oe, // pin drive enable, high drives
  output logic [63:0] wake_level // standby-well wake inputs
);
  gdb_state_type st_reg;
  gdb_state_type st_next;

  // fixed bank slots
  // bank lookup: {hit, bank number}
  function automatic logic [3:0] bank_sel(input logic [7:0] idx);
    logic [3:0] r;
    r = 4'h0;
    for (int b = 0; b < GDB_BANKS; b++) begin
      if (idx == GDB_BANK_IDX[b]) begin
        r = {1'b1, 3'(b)};
      end
    end
    return r;
  endfunction

  // read value of one bank: inputs from pins, outputs from held data
  function automatic logic [7:0] bank_val(input gdb_state_type s,
      input logic [2:0] b, input logic [63:0] pins);
    logic [7:0] v;
    logic [5:0] n;
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      n = {b, 3'(i)};
      if (s.cfg[n][GDB_CFG_DIR]) begin
        v[i] = pins[n] ^ s.cfg[n][GDB_CFG_INV];
      end else begin
        v[i] = s.data[n];
      end
    end
    return v & ~GDB_BANK_RSVD[b];
  endfunction

  // next-state logic for bus, registers and pins
  always_comb begin
    logic [7:0] widx;
    logic [7:0] ridx;
    logic [3:0] wb;
    logic [3:0] rb;
    logic lvl;
    logic [2:0] wbn;
    widx = 8'h00;
    ridx = 8'h00;
    wb = 4'h0;
    rb = 4'h0;
    lvl = 1'b0;
    wbn = 3'h0;
    st_next = st_reg;
    // capture address and data in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // window bit ignored in decode, both views alias
    widx = st_reg.awaddr[9:2];
    wb = bank_sel(widx);
    wbn = wb[2:0];
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = GDB_RESP_OKAY;
      if (wb[3]) begin
        if (st_reg.wstrb[0]) begin
          for (int i = 0; i < 8; i++) begin
            if (!GDB_BANK_RSVD[wbn][i]) begin
              st_next.data[{wbn, 3'(i)}] = st_reg.wdata[i];
            end
          end
        end
      end else if (widx[7:6] == GDB_IDX_CFG_BASE[7:6]) begin
        if (st_reg.wstrb[0]) begin
          st_next.cfg[widx[5:0]] = st_reg.wdata[7:0];
        end
      end else begin
        st_next.bresp = GDB_RESP_SLVERR;
      end
    end
    st_next.awready = !st_next.aw_have;
    st_next.wready = !st_next.w_have;
    // read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      ridx = s_axi_araddr[9:2];
      rb = bank_sel(ridx);
      st_next.rvalid = 1'b1;
      st_next.rresp = GDB_RESP_OKAY;
      if (rb[3]) begin
        st_next.rdata = {24'h0, bank_val(st_reg, rb[2:0], pin_in)};
      end else if (ridx[7:6] == GDB_IDX_CFG_BASE[7:6]) begin
        st_next.rdata = {24'h0, st_reg.cfg[ridx[5:0]]};
      end else begin
        st_next.rdata = 32'h0;
        st_next.rresp = GDB_RESP_SLVERR;
      end
    end
    st_next.arready = !st_next.rvalid;
    // pin drivers follow the new data and config in the same edge
    for (int n = 0; n < GDB_PORTS; n++) begin
      lvl = st_next.data[n] ^ st_next.cfg[n][GDB_CFG_INV];
      if (st_next.cfg[n][GDB_CFG_DIR]) begin
        st_next.pin_out[n] = 1'b0;
        st_next.pin_oe[n] = 1'b0;
      end else if (st_next.cfg[n][GDB_CFG_ODRAIN]) begin
        st_next.pin_out[n] = 1'b0;
        st_next.pin_oe[n] = !lvl;
      end else begin
        st_next.pin_out[n] = lvl;
        st_next.pin_oe[n] = 1'b1;
      end
    end
    // wake path ignores direction, it sits on the standby well
    st_next.wake = pin_in & WAKE_MASK;
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.cfg <= {GDB_PORTS{GDB_CFG_RST}};
      st_reg.data <= GDB_DATA_RST;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign pin_out = st_reg.pin_out;
  assign pin_oe = st_reg.pin_oe;
  assign wake_level = st_reg.wake;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rd_bank_one;
    s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[9:2] == GDB_IDX_BANK_ONE;
  endsequence
  sequence s_wr_go;
    st_reg.aw_have && st_reg.w_have && !st_reg.bvalid && st_reg.wstrb[0];
  endsequence

  property p_rd_input;
    s_rd_bank_one and (st_reg.cfg[0][GDB_CFG_DIR] == 1'b1) |=>
      s_axi_rvalid && s_axi_rdata[0] ==
      ($past(pin_in[0]) ^ $past(st_reg.cfg[0][GDB_CFG_INV]));
  endproperty
  a_rd_input: assert property (p_rd_input)
    else $error("input read does not return pin level");

  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read snapshot changed before taken");

  // pins move freely, read data only moves at a new read
  property p_rd_snap;
    !(s_axi_arvalid && s_axi_arready) |=> $stable(s_axi_rdata);
  endproperty
  a_rd_snap: assert property (p_rd_snap)
    else $error("read data moved without a new read");

  property p_drive;
    st_reg.cfg[8][GDB_CFG_DIR] == 1'b0 &&
      st_reg.cfg[8][GDB_CFG_ODRAIN] == 1'b0 |->
      pin_oe[8] && pin_out[8] ==
      (st_reg.data[8] ^ st_reg.cfg[8][GDB_CFG_INV]);
  endproperty
  a_drive: assert property (p_drive)
    else $error("output pin does not follow held bit");

  property p_odrain;
    st_reg.cfg[8][GDB_CFG_DIR] == 1'b0 &&
      st_reg.cfg[8][GDB_CFG_ODRAIN] |->
      !pin_out[8] && pin_oe[8] ==
      !(st_reg.data[8] ^ st_reg.cfg[8][GDB_CFG_INV]);
  endproperty
  a_odrain: assert property (p_odrain)
    else $error("open drain pin drives high");

  property p_rsvd;
    st_reg.data[31:28] == 4'h0 && st_reg.data[47:43] == 5'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bank bit holds a one");

  property p_cfg_wr;
    s_wr_go and (st_reg.awaddr[9:2] == GDB_IDX_CFG_BASE) |=>
      st_reg.cfg[0] == $past(st_reg.wdata[7:0]) && s_axi_bvalid;
  endproperty
  a_cfg_wr: assert property (p_cfg_wr)
    else $error("config write not stored");

  property p_bank_map;
    s_wr_go and (st_reg.awaddr[9:2] == GDB_IDX_BANK_TWO) |=>
      st_reg.data[15:8] == $past(st_reg.wdata[7:0]);
  endproperty
  a_bank_map: assert property (p_bank_map)
    else $error("bank two bits not at ports eight to fifteen");

  property p_alias;
    s_wr_go and (st_reg.awaddr[GDB_WIN_BIT] == 1'b1) and
      (st_reg.awaddr[9:2] == GDB_IDX_BANK_EIGHT) |=>
      st_reg.data[63:56] == $past(st_reg.wdata[7:0]) &&
      s_axi_bresp == GDB_RESP_OKAY;
  endproperty
  a_alias: assert property (p_alias)
    else $error("config window write missed");

  property p_wake;
    $past(rstn) |-> wake_level == ($past(pin_in) & WAKE_MASK);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake level does not track pins");

  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid[*1] ##0 $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped early");
endmodule

/* File: dv/gdb_board.sv */
// board-side model of the general purpose pins
`timescale 1ns/1ps
module gdb_board (
  input wire logic [63:0] pin_out, // design drive level
  input wire logic [63:0] pin_oe, // design drive enable
  input wire logic [63:0] ext_level, // level of the outside drivers
  output logic [63:0] pin_in // resolved pin level
);
  // outside drivers are weak: the device wins where it drives
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* File: dv/test_gpio_data_bank.sv */
// self-checking bench for the banked gpio data path
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module test_gpio_data_bank;
  import gdb_pkg::*;
  logic clk, rstn, awvalid, wvalid, arvalid, bvalid, rvalid;
  logic awready, wready, arready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  logic [63:0] pin_in, pin_out, pin_oe, wake_level, ext_level;
  int errors = 0;
  int total_checks = 0;
  gdb_top u_gdb_top (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .wake_level(wake_level));
  gdb_board u_gdb_board (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_level(ext_level), .pin_in(pin_in));
  // clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // a used-up wait bound ends the run
  task guard(input int n);
    if (n >= 40) begin
      errors++;
      end_of_test();
    end
  endtask
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  // axi write: aw and w offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready || wvalid && !wready) && n < 40);
    do begin
      @(posedge clk);
      n++;
    end while (!bvalid && n < 40);
    guard(n);
    `CHK(bresp, er)
  endtask
  // axi read: compare the whole word, upper bits must be zero
  task automatic rd(input logic [11:0] a, input logic [7:0] e,
      input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!arready && n < 40);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (!rvalid && n < 40);
    guard(n);
    `CHK(rdata, {24'h0, e})
    `CHK(rresp, er)
  endtask
  // main sequence
  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'b000;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h1;
    ext_level = 64'hc3a5f00fe1963c5a;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(ba(GDB_IDX_CFG_BASE), GDB_CFG_RST, GDB_RESP_OKAY);
    wr(ba(GDB_IDX_BANK_FOUR), 8'hff, GDB_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      rd(ba(GDB_BANK_IDX[i]), ext_level[i*8 +: 8] & ~GDB_BANK_RSVD[i],
        GDB_RESP_OKAY);
    end
    rd(12'h800 | ba(GDB_IDX_BANK_ONE), 8'h5a, GDB_RESP_OKAY);
    wr(12'h800 | ba(GDB_IDX_BANK_EIGHT), 8'h81, GDB_RESP_OKAY);
    `CHK(wake_level, pin_in)
    // port 8 push-pull output, then inverted, then open drain
    wr(ba(8'h88), 8'h00, GDB_RESP_OKAY);
    wr(ba(GDB_IDX_BANK_TWO), 8'h01, GDB_RESP_OKAY);
    `CHK(pin_oe[8], 1'b1)
    `CHK(pin_out[8], 1'b1)
    rd(ba(GDB_IDX_BANK_TWO), 8'h3d, GDB_RESP_OKAY);
    wr(ba(8'h88), 8'h02, GDB_RESP_OKAY);
    `CHK(pin_out[8], 1'b0)
    wr(ba(8'h88), 8'h80, GDB_RESP_OKAY);
    `CHK(pin_oe[8], 1'b0)
    wr(ba(GDB_IDX_BANK_TWO), 8'h00, GDB_RESP_OKAY);
    `CHK(pin_oe[8], 1'b1)
    `CHK(pin_out[8], 1'b0)
    // low strobe off: the held bit must not change
    wstrb <= 4'h0;
    wr(ba(GDB_IDX_BANK_TWO), 8'h01, GDB_RESP_OKAY);
    wstrb <= 4'h1;
    `CHK(pin_oe[8], 1'b1)
    // inverted input on port 0
    wr(ba(GDB_IDX_CFG_BASE), 8'h03, GDB_RESP_OKAY);
    rd(ba(GDB_IDX_BANK_ONE), 8'h5b, GDB_RESP_OKAY);
    // unmapped index answers with an error and reads zero
    wr(ba(8'h10), 8'h55, GDB_RESP_SLVERR);
    rd(ba(8'h10), 8'h00, GDB_RESP_SLVERR);
    end_of_test();
  end
endmodule
